// file: hdl/addressing_mode_decoder.sv
// Operand-address and instruction-length decoder of the 8-bit core.
`timescale 1ns/1ns
`include "amd_params.svh"
module addressing_mode_decoder (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Program memory, read data valid in the same cycle as progRd
    output amd_pkg::pc_t progAddr,
    output logic progRd,
    input wire logic [7:0] progData,
    // Data space, read data valid in the same cycle as dataRd
    output logic [7:0] dataAddr,
    output logic dataRd,
    output logic dataWr,
    output logic [7:0] dataWrData,
    input wire logic [7:0] dataRdData,
    // Core side
    input wire logic condTrue,
    input wire logic coreWr,
    input wire logic [7:0] coreAddr,
    input wire logic [7:0] coreData,
    input wire logic irqReq,
    input wire amd_pkg::pc_t irqVector,
    // Decode results
    output logic [7:0] opcode,
    output amd_pkg::mode_e mode,
    output logic [1:0] instrLen,
    output logic [7:0] operand,
    output amd_pkg::pc_t pc,
    output logic carry,
    output logic instrDone,
    output logic stackOverflow
);
    import amd_pkg::*;

    typedef struct packed {
        state_e st;
        pc_t pc;
        pc_t nextPc;
        pc_t progAddr;
        logic progRd;
        logic [7:0] dataAddr;
        logic dataRd;
        logic dataWr;
        logic [7:0] dataWrData;
        logic [7:0] opcode;
        mode_e mode;
        logic [1:0] len;
        logic [7:0] addrByte;
        logic [7:0] operand;
        logic carry;
        logic done;
        logic isRet;
        logic push;
        pc_t pushData;
        logic pop;
        logic irqPend;
        logic over;
    } dec_s;

    dec_s s_q;
    dec_s s_d;
    logic [7:0] pointerA;
    logic [7:0] pointerB;
    pc_t popData;
    logic stkOver;
    logic snoopWr;
    logic [7:0] snoopAddr;
    logic [7:0] snoopData;

    // The block's own bit writes reach the pointers, and the core's writes do in any cycle in which the block is not writing.
    assign snoopWr = s_q.dataWr | coreWr;
    assign snoopAddr = s_q.dataWr ? s_q.dataAddr : coreAddr;
    assign snoopData = s_q.dataWr ? s_q.dataWrData : coreData;

    short_regs uRegs (
        .clk(clk),
        .rst_n(rst_n),
        .wrEn(snoopWr),
        .wrAddr(snoopAddr),
        .wrData(snoopData),
        .pointerA(pointerA),
        .pointerB(pointerB)
    );

    return_stack uStack (
        .clk(clk),
        .rst_n(rst_n),
        .push(s_q.push),
        .pop(s_q.pop),
        .pushData(s_q.pushData),
        .popData(popData),
        .overflow(stkOver)
    );

    // Opcode map: low nibble even is relative, 1 call, 9 long_jump_op, 3 bit test,
    // B bit direct, 5 short direct, 7 indirect or immediate, F direct, D inherent.
    function automatic mode_e decodeMode(input logic [7:0] op);
        mode_e m;
        m = MODE_INH;
        if (!op[0]) begin
            m = MODE_REL;
        end else begin
            unique case (op[3:1])
                3'h0, 3'h4: m = MODE_EXT;
                3'h1: m = MODE_BTB;
                3'h5: m = MODE_BDIR;
                3'h2: m = MODE_SDIR;
                3'h3: m = op[5] ? MODE_IMM : MODE_IND;
                3'h7: m = MODE_DIR;
                3'h6: m = MODE_INH;
            endcase
        end
        return m;
    endfunction

    always_comb begin
        logic [7:0] op;
        mode_e m;
        pc_t tgt;
        logic [7:0] bitMask;
        logic bitVal;
        op = 8'h00;
        m = MODE_INH;
        tgt = 12'h000;
        bitMask = 8'h00;
        bitVal = 1'b0;
        s_d = s_q;
        s_d.progRd = 1'b0;
        s_d.dataRd = 1'b0;
        s_d.dataWr = 1'b0;
        s_d.done = 1'b0;
        s_d.push = 1'b0;
        s_d.pop = 1'b0;
        s_d.over = stkOver;
        if (irqReq) begin
            s_d.irqPend = 1'b1;
        end
        bitMask = 8'h01 << s_q.opcode[7:5];
        unique case (s_q.st)
            ST_FETCH: begin
                if (s_q.irqPend || irqReq) begin
                    // Interrupt entry stacks the address of the instruction not yet run.
                    s_d.irqPend = 1'b0;
                    s_d.push = 1'b1;
                    s_d.pushData = s_q.pc;
                    s_d.pc = irqVector;
                end else begin
                    s_d.progRd = 1'b1;
                    s_d.progAddr = s_q.pc;
                    s_d.st = ST_OPC;
                end
            end
            ST_OPC: begin
                op = progData;
                m = decodeMode(op);
                s_d.opcode = op;
                s_d.mode = m;
                s_d.isRet = 1'b0;
                s_d.nextPc = s_q.pc + 12'h001;
                s_d.st = ST_DONE;
                unique case (m)
                    MODE_REL: begin
                        s_d.len = `AMD_LEN_ONE;
                        // Forward spans count from the next byte, and the offset nibble is even, so -14..+15 is reached.
                        if (op[4]) begin
                            tgt = s_q.pc - {8'h00, op[3:0]};
                        end else begin
                            tgt = s_q.pc + 12'h001 + {8'h00, op[3:0]};
                        end
                        if (condTrue) begin
                            s_d.nextPc = tgt;
                        end
                    end
                    MODE_SDIR: begin
                        s_d.len = `AMD_LEN_ONE;
                        s_d.dataAddr = `AMD_PTR_A_ADDR | {6'h00, op[7:6]};
                        s_d.dataRd = 1'b1;
                    end
                    MODE_IND: begin
                        s_d.len = `AMD_LEN_ONE;
                        s_d.dataAddr = op[4] ? pointerB : pointerA;
                        s_d.dataRd = 1'b1;
                    end
                    MODE_INH: begin
                        s_d.len = `AMD_LEN_ONE;
                        if (op == `AMD_RET_OPCODE) begin
                            s_d.isRet = 1'b1;
                            s_d.pop = 1'b1;
                        end
                    end
                    default: begin
                        s_d.progRd = 1'b1;
                        s_d.progAddr = s_q.pc + 12'h001;
                        s_d.len = (m == MODE_BTB) ? `AMD_LEN_THREE : `AMD_LEN_TWO;
                        s_d.nextPc = s_q.pc + ((m == MODE_BTB) ? 12'h003 : 12'h002);
                        s_d.st = ST_B2;
                    end
                endcase
            end
            ST_B2: begin
                s_d.addrByte = progData;
                s_d.st = ST_DONE;
                unique case (s_q.mode)
                    MODE_IMM: begin
                        s_d.operand = progData;
                    end
                    MODE_DIR: begin
                        s_d.dataAddr = progData;
                        s_d.dataRd = 1'b1;
                    end
                    MODE_EXT: begin
                        tgt = {s_q.opcode[3:0], progData};
                        s_d.nextPc = tgt;
                        if (!s_q.opcode[3]) begin
                            s_d.push = 1'b1;
                            s_d.pushData = s_q.pc + 12'h002;
                        end
                    end
                    MODE_BDIR: begin
                        s_d.dataAddr = progData;
                        s_d.dataRd = 1'b1;
                        s_d.st = ST_BMOD;
                    end
                    default: begin
                        s_d.progRd = 1'b1;
                        s_d.progAddr = s_q.pc + 12'h002;
                        s_d.st = ST_B3;
                    end
                endcase
            end
            ST_B3: begin
                s_d.operand = progData;
                s_d.dataAddr = s_q.addrByte;
                s_d.dataRd = 1'b1;
                s_d.st = ST_BTST;
            end
            ST_BTST: begin
                bitVal = |(dataRdData & bitMask);
                s_d.carry = bitVal;
                // Opcode bit 4 set branches on a set bit, clear on a cleared bit.
                if (bitVal == s_q.opcode[4]) begin
                    tgt = s_q.pc + 12'h001 + {{4{s_q.operand[7]}}, s_q.operand};
                    s_d.nextPc = tgt;
                end
                s_d.st = ST_DONE;
            end
            ST_BMOD: begin
                s_d.carry = |(dataRdData & bitMask);
                s_d.dataAddr = s_q.addrByte;
                s_d.dataWr = 1'b1;
                // Opcode bit 4 clear is bit_clear_op, set is the bit set.
                if (s_q.opcode[4]) begin
                    s_d.dataWrData = dataRdData | bitMask;
                end else begin
                    s_d.dataWrData = dataRdData & ~bitMask;
                end
                s_d.st = ST_DONE;
            end
            ST_DONE: begin
                if (s_q.mode == MODE_DIR || s_q.mode == MODE_SDIR || s_q.mode == MODE_IND) begin
                    s_d.operand = dataRdData;
                end
                s_d.pc = s_q.isRet ? popData : s_q.nextPc;
                s_d.isRet = 1'b0;
                s_d.done = 1'b1;
                s_d.st = ST_FETCH;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s_q <= '{st: ST_FETCH, pc: `AMD_PC_RESET, nextPc: `AMD_PC_RESET,
                     progAddr: 12'h000, dataAddr: 8'h00, dataWrData: 8'h00,
                     opcode: 8'h00, mode: MODE_INH, len: `AMD_LEN_ONE,
                     addrByte: 8'h00, operand: 8'h00, pushData: 12'h000,
                     default: 1'b0};
        end else begin
            s_q <= s_d;
        end
    end

    assign progAddr = s_q.progAddr;
    assign progRd = s_q.progRd;
    assign dataAddr = s_q.dataAddr;
    assign dataRd = s_q.dataRd;
    assign dataWr = s_q.dataWr;
    assign dataWrData = s_q.dataWrData;
    assign opcode = s_q.opcode;
    assign mode = s_q.mode;
    assign instrLen = s_q.len;
    assign operand = s_q.operand;
    assign pc = s_q.pc;
    assign carry = s_q.carry;
    assign instrDone = s_q.done;
    assign stackOverflow = s_q.over;
endmodule // addressing_mode_decoder

// file: hdl/amd_params.svh
// Constants for the addressing-mode decoder.
`ifndef AMD_PARAMS_SVH
`define AMD_PARAMS_SVH
`define AMD_PTR_A_ADDR 8'h80
`define AMD_PTR_B_ADDR 8'h81
`define AMD_SCR_A_ADDR 8'h82
`define AMD_SCR_B_ADDR 8'h83
`define AMD_STACK_DEPTH 6
`define AMD_PC_RESET 12'h000
`define AMD_RET_OPCODE 8'hcd
`define AMD_LEN_ONE 2'h1
`define AMD_LEN_TWO 2'h2
`define AMD_LEN_THREE 2'h3
`endif

// file: hdl/amd_pkg.sv
// Types shared by the addressing-mode decoder files.
package amd_pkg;
    typedef enum logic [8:0] {
        MODE_IMM = 9'h001,
        MODE_DIR = 9'h002,
        MODE_SDIR = 9'h004,
        MODE_EXT = 9'h008,
        MODE_REL = 9'h010,
        MODE_BDIR = 9'h020,
        MODE_BTB = 9'h040,
        MODE_IND = 9'h080,
        MODE_INH = 9'h100
    } mode_e;
    typedef enum logic [6:0] {
        ST_FETCH = 7'h01,
        ST_OPC = 7'h02,
        ST_B2 = 7'h04,
        ST_B3 = 7'h08,
        ST_BTST = 7'h10,
        ST_BMOD = 7'h20,
        ST_DONE = 7'h40
    } state_e;
    typedef logic [11:0] pc_t;
endpackage

// file: hdl/return_stack.sv
// Six-cell, 12-bit return-address stack with registered read data.
`timescale 1ns/1ns
`include "amd_params.svh"
module return_stack (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Stack operations
    input wire logic push,
    input wire logic pop,
    input wire amd_pkg::pc_t pushData,
    output amd_pkg::pc_t popData,
    output logic overflow
);
    import amd_pkg::*;
    pc_t cells_q [`AMD_STACK_DEPTH];
    logic [2:0] depth_q;
    pc_t popData_q;
    logic over_q;
    assign popData = popData_q;
    assign overflow = over_q;
    // A push into a full stack drops the oldest entry, as a small hardware stack would.
    // The read register always holds the top cell. A pop can then use it in the cycle
    // in which the pop is strobed, without waiting a cycle for the read data.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            depth_q <= 3'h0;
            popData_q <= 12'h000;
            over_q <= 1'b0;
        end else if (push) begin
            for (int i = `AMD_STACK_DEPTH - 1; i > 0; i--) begin
                cells_q[i] <= cells_q[i-1];
            end
            cells_q[0] <= pushData;
            popData_q <= pushData;
            if (depth_q == 3'(`AMD_STACK_DEPTH)) begin
                over_q <= 1'b1;
            end else begin
                depth_q <= depth_q + 3'h1;
            end
        end else if (pop) begin
            popData_q <= cells_q[1];
            for (int i = 0; i < `AMD_STACK_DEPTH - 1; i++) begin
                cells_q[i] <= cells_q[i+1];
            end
            if (depth_q != 3'h0) begin
                depth_q <= depth_q - 3'h1;
            end
        end
    end
endmodule // return_stack

// file: hdl/short_regs.sv
// The four short-direct registers: two pointers and two scratch bytes.
`timescale 1ns/1ns
`include "amd_params.svh"
module short_regs (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Data-space write snoop
    input wire logic wrEn,
    input wire logic [7:0] wrAddr,
    input wire logic [7:0] wrData,
    // Pointer contents
    output logic [7:0] pointerA,
    output logic [7:0] pointerB
);
    logic [7:0] regs_q [4];
    assign pointerA = regs_q[0];
    assign pointerB = regs_q[1];
    genvar g;
    for (g = 0; g < 4; g++) begin : gReg
        always_ff @(posedge clk) begin
            if (!rst_n) begin
                regs_q[g] <= 8'h00;
            end else if (wrEn && wrAddr == `AMD_PTR_A_ADDR + 8'(g)) begin
                regs_q[g] <= wrData;
            end
        end
    end
endmodule // short_regs

// file: tb/amd_properties.sv
// Port-level checks for the addressing-mode decoder.
`timescale 1ns/1ns
module amd_properties (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Buses
    input wire amd_pkg::pc_t progAddr,
    input wire logic progRd,
    input wire logic [7:0] dataAddr,
    input wire logic dataRd,
    input wire logic dataWr,
    input wire logic irqReq,
    // Decode results
    input wire logic [7:0] opcode,
    input wire amd_pkg::mode_e mode,
    input wire logic [1:0] instrLen,
    input wire amd_pkg::pc_t pc,
    input wire logic instrDone,
    input wire logic stackOverflow
);
    import amd_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_doneThenFetch;
        (instrDone && !irqReq) ##1 1'b1;
    endsequence
    sequence s_twoReads;
        progRd ##1 progRd;
    endsequence
    property p_donePulse;
        instrDone |=> !instrDone;
    endproperty
    a_donePulse: assert property (p_donePulse)
        else $error("instrDone wider than one cycle");
    property p_lenOne;
        instrDone && mode inside {MODE_SDIR, MODE_REL, MODE_IND, MODE_INH} |-> instrLen == 2'h1;
    endproperty
    a_lenOne: assert property (p_lenOne)
        else $error("one-byte mode reports wrong length");
    property p_lenTwo;
        instrDone && mode inside {MODE_IMM, MODE_DIR, MODE_EXT, MODE_BDIR} |-> instrLen == 2'h2;
    endproperty
    a_lenTwo: assert property (p_lenTwo)
        else $error("two-byte mode reports wrong length");
    property p_lenThree;
        instrDone && mode == MODE_BTB |-> instrLen == 2'h3;
    endproperty
    a_lenThree: assert property (p_lenThree)
        else $error("bit test length is not three");
    property p_seqAddr;
        s_twoReads |-> progAddr == $past(progAddr) + 12'h001;
    endproperty
    a_seqAddr: assert property (p_seqAddr)
        else $error("operand byte not read right after opcode");
    property p_fetchAfterDone;
        s_doneThenFetch |-> progRd && progAddr == pc;
    endproperty
    a_fetchAfterDone: assert property (p_fetchAfterDone)
        else $error("next fetch not at updated pc");
    property p_pcAtDone;
        $changed(pc) && !$past(irqReq) |-> instrDone;
    endproperty
    a_pcAtDone: assert property (p_pcAtDone)
        else $error("pc moved without instrDone");
    property p_wrAfterRd;
        dataWr |-> $past(dataRd) && dataAddr == $past(dataAddr);
    endproperty
    a_wrAfterRd: assert property (p_wrAfterRd)
        else $error("bit write without read of same byte");
    property p_sticky;
        stackOverflow |=> stackOverflow;
    endproperty
    a_sticky: assert property (p_sticky)
        else $error("stackOverflow cleared without reset");
    property p_extTarget;
        instrDone && mode == MODE_EXT |-> pc[11:8] == opcode[3:0];
    endproperty
    a_extTarget: assert property (p_extTarget)
        else $error("extended target upper nibble wrong");
endmodule // amd_properties

bind addressing_mode_decoder amd_properties u_props (
    .clk, .rst_n, .progAddr, .progRd, .dataAddr, .dataRd, .dataWr, .irqReq,
    .opcode, .mode, .instrLen, .pc, .instrDone, .stackOverflow
);

// file: tb/mem_model.sv
// Program and data memory model answering the decoder's two read buses.
`timescale 1ns/1ns
module mem_model (
    // Clock
    input wire logic clk,
    // Program bus
    input wire amd_pkg::pc_t progAddr,
    input wire logic progRd,
    output logic [7:0] progData,
    // Data bus
    input wire logic [7:0] dataAddr,
    input wire logic dataRd,
    input wire logic dataWr,
    input wire logic [7:0] dataWrData,
    output logic [7:0] dataRdData
);
    import amd_pkg::*;
    logic [7:0] pmem [4096];
    logic [7:0] dmem [256];
    logic [7:0] idleProg;
    logic [7:0] idleData;
    initial begin
        idleProg = 8'h00;
        idleData = 8'h00;
    end
    // Read data stand while the strobe is high, which is when the decoder samples them.
    // Idle bytes toggle every cycle, so a sample taken a cycle late is caught.
    assign progData = progRd ? pmem[progAddr] : idleProg;
    assign dataRdData = dataRd ? dmem[dataAddr] : idleData;
    always @(posedge clk) begin
        idleProg <= ~idleProg;
        idleData <= ~idleData;
        if (dataWr) begin
            dmem[dataAddr] <= dataWrData;
        end
    end
endmodule // mem_model

// file: tb/tb_addressing_mode_decoder.sv
// Bench that runs a short program through the decoder and checks each result.
`timescale 1ns/1ns
module tb_addressing_mode_decoder;
    import amd_pkg::*;
    localparam logic [8:0] NO = 9'h100;
    localparam logic [19:0] IMG [26] = '{20'h0000f, 20'h00190, 20'h00227, 20'h0033c,
        20'h00407, 20'h00517, 20'h00685, 20'h0070d, 20'h00804, 20'h0090e, 20'h0181a,
        20'h00e3b, 20'h00f70, 20'h0102b, 20'h01170, 20'h01203, 20'h01370, 20'h0142d,
        20'h04003, 20'h04170, 20'h042f0, 20'h03111, 20'h03223, 20'h123cd, 20'h03399,
        20'h03400};
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic condTrue = 1'b0;
    logic coreWr = 1'b0;
    logic irqReq = 1'b0;
    logic [7:0] coreAddr = 8'h00;
    logic [7:0] coreData = 8'h00;
    pc_t irqVector = 12'h000;
    pc_t progAddr, pc;
    logic progRd, dataRd, dataWr, carry, instrDone, stackOverflow;
    logic [7:0] progData, dataAddr, dataWrData, dataRdData, opcode, operand;
    logic [1:0] instrLen;
    mode_e mode;
    int err_count = 0;
    int check_count = 0;
    int cycles = 0;
    always #4 clk = ~clk;
    addressing_mode_decoder dut (.clk, .rst_n, .progAddr, .progRd, .progData, .dataAddr,
        .dataRd, .dataWr, .dataWrData, .dataRdData, .condTrue, .coreWr, .coreAddr, .coreData,
        .irqReq, .irqVector, .opcode, .mode, .instrLen, .operand, .pc, .carry, .instrDone,
        .stackOverflow);
    mem_model mdl (.clk, .progAddr, .progRd, .progData, .dataAddr, .dataRd, .dataWr,
        .dataWrData, .dataRdData);
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", check_count, err_count);
        if (err_count == 0 && check_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Waits for the end of one instruction, then compares its decode results.
    task automatic step(input logic c, input mode_e m, input logic [1:0] l, input pc_t p,
                        input logic [8:0] o);
        int n;
        condTrue = c;
        n = 0;
        while (instrDone !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        if (n == 20) begin
            err_count++;
        end
        chk(16'(mode), 16'(m));
        chk(16'(instrLen), 16'(l));
        chk(16'(pc), 16'(p));
        if (!o[8]) begin
            chk(16'(operand), 16'(o[7:0]));
        end
        @(negedge clk);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            err_count++;
            close_out();
        end
    end
    initial begin
        int n;
        foreach (mdl.pmem[i]) mdl.pmem[i] = 8'h0d;
        foreach (mdl.dmem[i]) mdl.dmem[i] = 8'h00;
        foreach (IMG[i]) mdl.pmem[IMG[i][19:8]] = IMG[i][7:0];
        mdl.dmem[8'h90] = 8'h5a;
        mdl.dmem[8'h40] = 8'h11;
        mdl.dmem[8'h41] = 8'h22;
        mdl.dmem[8'h82] = 8'h33;
        repeat (3) @(negedge clk);
        chk(16'(pc), 16'h0000);
        chk(16'(mode), 16'(MODE_INH));
        chk(16'(instrLen), 16'h0001);
        rst_n = 1'b1;
        coreWr = 1'b1;
        coreAddr = 8'h80;
        coreData = 8'h40;
        @(negedge clk);
        coreAddr = 8'h81;
        coreData = 8'h41;
        @(negedge clk);
        coreWr = 1'b0;
        step(1'b0, MODE_DIR, 2'h2, 12'h002, 9'h05a);
        step(1'b0, MODE_IMM, 2'h2, 12'h004, 9'h03c);
        step(1'b0, MODE_IND, 2'h1, 12'h005, 9'h011);
        step(1'b0, MODE_IND, 2'h1, 12'h006, 9'h022);
        step(1'b0, MODE_SDIR, 2'h1, 12'h007, 9'h033);
        step(1'b0, MODE_INH, 2'h1, 12'h008, NO);
        step(1'b0, MODE_REL, 2'h1, 12'h009, NO);
        step(1'b1, MODE_REL, 2'h1, 12'h018, NO);
        step(1'b1, MODE_REL, 2'h1, 12'h00e, NO);
        step(1'b0, MODE_BDIR, 2'h2, 12'h010, NO);
        chk(16'(carry), 16'h0000);
        chk(16'(mdl.dmem[8'h70]), 16'h0002);
        step(1'b0, MODE_BDIR, 2'h2, 12'h012, NO);
        chk(16'(carry), 16'h0001);
        chk(16'(mdl.dmem[8'h70]), 16'h0000);
        step(1'b0, MODE_BTB, 2'h3, 12'h040, NO);
        step(1'b0, MODE_BTB, 2'h3, 12'h031, NO);
        step(1'b0, MODE_EXT, 2'h2, 12'h123, NO);
        step(1'b0, MODE_INH, 2'h1, 12'h033, NO);
        step(1'b0, MODE_EXT, 2'h2, 12'h900, NO);
        // The seventh entry overfills the six-cell stack. Vectors sit far apart so that
        // plain execution from one vector never lands on the next.
        for (int i = 0; i < 7; i++) begin
            irqVector = 12'h200 + 12'(i * 16);
            irqReq = 1'b1;
            n = 0;
            while (pc !== irqVector && n < 20) begin
                @(negedge clk);
                n++;
            end
            irqReq = 1'b0;
            if (n == 20) begin
                err_count++;
            end
            chk(16'(pc), 16'h0200 + 16'(i * 16));
            repeat (4) @(negedge clk);
            chk(16'(stackOverflow), 16'(i == 6));
        end
        close_out();
    end
endmodule // tb_addressing_mode_decoder
